// ---- egtr_map.svh ----
// register map, field positions, reset values and timing for the egress tag and rate block
// assumes a 32-bit register bus with word indexes; byte address is four times the index
`ifndef EGTR_MAP_SVH
`define EGTR_MAP_SVH

// word indexes of the registers
`define EGTR_IDX_TAG_RULES 14'h1c0c
`define EGTR_IDX_RATE_P0_Q01 14'h1c0d
`define EGTR_IDX_RATE_P0_Q23 14'h1c0e
`define EGTR_IDX_RATE_P1_Q01 14'h1c0f

// tagging rules: each port owns one byte lane, fields at these offsets inside the lane
`define EGTR_PORT_LANE_BITS 8
`define EGTR_FLD_TYPE_LO 0
`define EGTR_FLD_TYPE_HI 1
`define EGTR_FLD_CHANGE_TAG 2
`define EGTR_FLD_CHANGE_PRI 3
`define EGTR_FLD_CHANGE_VID 4
`define EGTR_FLD_INSERT_TAG 5

// rate register fields
`define EGTR_FLD_RATE_EVEN_LO 0
`define EGTR_FLD_RATE_EVEN_HI 12
`define EGTR_FLD_RATE_ODD_LO 13
`define EGTR_FLD_RATE_ODD_HI 25

// writable bits and reset values
`define EGTR_MASK_TAG_RULES 32'h003f3f3f
`define EGTR_MASK_RATE 32'h03ffffff
`define EGTR_RST_TAG_RULES 32'h00000000
`define EGTR_RST_RATE 32'h00000000

// timing: one pacing unit per byte step, and the clock period
`define EGTR_PACE_UNIT_NS 20
`define EGTR_CLK_PERIOD_NS 8

`endif

// ---- egtr_pkg.sv ----
// types shared by the egress tag and rate block
// assumes egtr_map.svh supplies the numeric constants
package egtr_pkg;

	// egress port type encoding, identical for every port
	typedef enum logic [1:0] {
		EGTR_TYPE_DUMB = 2'h0,
		EGTR_TYPE_ACCESS = 2'h1,
		EGTR_TYPE_HYBRID = 2'h2,
		EGTR_TYPE_CPU = 2'h3
	} egtr_port_type_t;

	// axi response codes used by the slave
	typedef enum logic [1:0] {
		EGTR_RESP_OKAY = 2'h0,
		EGTR_RESP_SLVERR = 2'h2
	} egtr_resp_t;

	typedef logic [12:0] egtr_rate_t;

endpackage

// ---- egtr_pacer.sv ----
// one egress pacing slot: after each byte, holds back the next one for (rate+1) pacing units
// assumes byte_sent_in is a one-cycle pulse and is only raised while credit_out is high
`timescale 1ns/1ps
`default_nettype none

module egtr_pacer
	import egtr_pkg::*;
(
	input wire logic clock_in,
	input wire logic srst_in,
	input wire egtr_rate_t rate_in,
	input wire logic enable_in,
	input wire logic byte_sent_in,
	output logic credit_out
);
	`include "egtr_map.svh"

	localparam logic [17:0] UNIT_NS = 18'(`EGTR_PACE_UNIT_NS);
	localparam logic [17:0] STEP_NS = 18'(`EGTR_CLK_PERIOD_NS);

	logic busy_reg;
	logic [17:0] elapsed_reg;
	logic [17:0] budget_ns;
	logic busy_next;

	// byte time in ns; 8192 units of 20 ns still fit in 18 bits
	assign budget_ns = 18'(({5'h0, rate_in} + 18'h1) * UNIT_NS);

	// slot stays closed until the elapsed time reaches the byte time, rounded up to a clock
	always_comb begin
		busy_next = busy_reg;
		if (!enable_in) begin
			busy_next = 1'b0;
		end else if (busy_reg) begin
			busy_next = (elapsed_reg + STEP_NS) < budget_ns;
		end else if (byte_sent_in) begin
			busy_next = 1'b1;
		end
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			busy_reg <= 1'b0;
			credit_out <= 1'b1;
		end else begin
			busy_reg <= busy_next;
			credit_out <= !busy_next;
		end
	end

	// elapsed time restarts at one clock on every accepted byte
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			elapsed_reg <= 18'h0;
		end else if (!busy_reg) begin
			elapsed_reg <= STEP_NS;
		end else begin
			elapsed_reg <= elapsed_reg + STEP_NS;
		end
	end

endmodule

`default_nettype wire

// ---- egtr_config.sv ----
// egress tagging rules and egress rate pacing configuration, reached over axi4-lite
// assumes a single clock, a synchronous reset, and a tagging datapath that applies
// the vlan table un-tag bit and the default vlan/priority values itself
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Each port has a two-bit egress type: port 2 at 17:16, port 1 at 9:8, host port at 1:0.
// - Type 00 passes regular frames untouched and strips the special tag of host-port frames.
// - Type 01 strips the tag of every tagged frame, special-tagged host frames included.
// - Type 10 is hybrid, where the insert and change enables pick what is done to tags.
// - Type 11 adds a special tag naming the port the frame came in on.
// - Port 1 insert, change-vid, change-priority and change-tag sit at bits 13, 12, 11, 10.
// - Host port insert, change-vid, change-priority and change-tag sit at bits 5, 4, 3, 2.
// - Each queue is paced so a byte takes the rate value plus one times 20 ns.
// - A rate register holds the odd queue in bits 25:13 and the even queue in bits 12:0.
// - Host queues 0/1 live at index 1c0d, host queues 2/3 at 1c0e, port 1 queues 0/1 at 1c0f.
// - Hybrid insert adds a default tag to untagged frames unless the vlan un-tag bit is set.
// - Hybrid change-vid with change-tag rewrites the vid of regular tagged frames.
// - Hybrid change-priority with change-tag rewrites the priority of regular tagged frames.
// - Priority-tagged frames always get the ingress default vid; change-tag does not matter. The code raises prio_vid_fix_out on hybrid ports only.
module egtr_config
	import egtr_pkg::*;
(
	input wire logic clock_in,
	input wire logic srst_in,
	// axi4-lite slave
	input wire logic [15:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [15:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// pacing enable from the buffer manager configuration
	input wire logic pace_enable_in,
	// per-queue byte pulses: host q0..q3 then port 1 q0..q1
	input wire logic [5:0] byte_sent_in,
	output logic [5:0] byte_credit_out,
	// per-port tagging controls, index 0 host, 1 port 1, 2 port 2
	output logic [5:0] port_type_out,
	output logic [2:0] strip_special_out,
	output logic [2:0] strip_all_out,
	output logic [2:0] hybrid_out,
	output logic [2:0] add_source_tag_out,
	output logic [2:0] insert_untagged_out,
	output logic [2:0] change_vid_out,
	output logic [2:0] change_pri_out,
	output logic [2:0] prio_vid_fix_out
);
	`include "egtr_map.svh"

	localparam int NUM_PORTS = 3;
	localparam int NUM_RATE_REGS = 3;
	localparam int NUM_QUEUES = 6;

	logic [31:0] tag_rules_reg;
	logic [31:0] rate_reg [NUM_RATE_REGS];

	// write channel state
	logic aw_held_reg;
	logic w_held_reg;
	logic [13:0] aw_index_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic do_write;
	logic wr_hit_tag;
	logic [1:0] wr_rate_sel;
	logic wr_hit_rate;

	// read channel decode
	logic [13:0] ar_index;
	logic [31:0] rd_word;
	logic rd_hit;

	// merge byte lanes under strobes, then keep only the implemented bits
	function automatic logic [31:0] egtr_merge(input logic [31:0] old_value,
		input logic [31:0] new_value, input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] merged;
		merged = old_value;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				merged[b*8 +: 8] = new_value[b*8 +: 8];
			end
		end
		return merged & mask;
	endfunction

	// ---- write address and data, taken in either order
	// a channel is taken once and held until the write commits, and ready waits for the response, so one write at a time
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			aw_held_reg <= 1'b0;
			aw_index_reg <= 14'h0;
		end else if (s_axi_awvalid_in && s_axi_awready_out) begin
			aw_held_reg <= 1'b1;
			aw_index_reg <= s_axi_awaddr_in[15:2];
		end else if (do_write) begin
			aw_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			w_held_reg <= 1'b0;
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
		end else if (s_axi_wvalid_in && s_axi_wready_out) begin
			w_held_reg <= 1'b1;
			w_data_reg <= s_axi_wdata_in;
			w_strb_reg <= s_axi_wstrb_in;
		end else if (do_write) begin
			w_held_reg <= 1'b0;
		end
	end

	// ready drops the edge after a channel is taken and comes back after the response
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out <= 1'b0;
		end else begin
			s_axi_awready_out <= !aw_held_reg && !(s_axi_awvalid_in && s_axi_awready_out)
				&& !s_axi_bvalid_out;
			s_axi_wready_out <= !w_held_reg && !(s_axi_wvalid_in && s_axi_wready_out)
				&& !s_axi_bvalid_out;
		end
	end

	// commit once both halves are in and no response is outstanding
	assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid_out;
	assign wr_hit_tag = aw_index_reg == `EGTR_IDX_TAG_RULES;
	assign wr_rate_sel = 2'(aw_index_reg - `EGTR_IDX_RATE_P0_Q01);
	assign wr_hit_rate = aw_index_reg >= `EGTR_IDX_RATE_P0_Q01
		&& aw_index_reg <= `EGTR_IDX_RATE_P1_Q01;

	// write response: slverr for an index that holds no register
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= EGTR_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid_out <= 1'b1;
			s_axi_bresp_out <= (wr_hit_tag || wr_hit_rate) ? EGTR_RESP_OKAY : EGTR_RESP_SLVERR;
		end else if (s_axi_bready_in) begin
			s_axi_bvalid_out <= 1'b0;
		end
	end

	// ---- tagging rules register; reserved bits are masked so they always read zero
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			tag_rules_reg <= `EGTR_RST_TAG_RULES;
		end else if (do_write && wr_hit_tag) begin
			tag_rules_reg <= egtr_merge(tag_rules_reg, w_data_reg, w_strb_reg,
				`EGTR_MASK_TAG_RULES);
		end
	end

	// ---- rate registers, three consecutive indexes
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			for (int r = 0; r < NUM_RATE_REGS; r++) begin
				rate_reg[r] <= `EGTR_RST_RATE;
			end
		end else if (do_write && wr_hit_rate) begin
			rate_reg[wr_rate_sel] <= egtr_merge(rate_reg[wr_rate_sel], w_data_reg,
				w_strb_reg, `EGTR_MASK_RATE);
		end
	end

	// ---- read channel: one read at a time, answered the edge after the address is taken
	assign ar_index = s_axi_araddr_in[15:2];

	always_comb begin
		rd_word = 32'h0;
		rd_hit = 1'b1;
		unique case (ar_index)
			`EGTR_IDX_TAG_RULES: rd_word = tag_rules_reg;
			`EGTR_IDX_RATE_P0_Q01: rd_word = rate_reg[0];
			`EGTR_IDX_RATE_P0_Q23: rd_word = rate_reg[1];
			`EGTR_IDX_RATE_P1_Q01: rd_word = rate_reg[2];
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			s_axi_arready_out <= 1'b0;
		end else begin
			s_axi_arready_out <= !s_axi_rvalid_out && !(s_axi_arvalid_in && s_axi_arready_out);
		end
	end

	// unmapped reads return zero with slverr
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0;
			s_axi_rresp_out <= EGTR_RESP_OKAY;
		end else if (s_axi_arvalid_in && s_axi_arready_out) begin
			s_axi_rvalid_out <= 1'b1;
			s_axi_rdata_out <= rd_word;
			s_axi_rresp_out <= rd_hit ? EGTR_RESP_OKAY : EGTR_RESP_SLVERR;
		end else if (s_axi_rready_in) begin
			s_axi_rvalid_out <= 1'b0;
		end
	end

	// ---- per-port tagging controls, one byte lane of the rules register per port
	// decoded into flops so the datapath sees one clean level per action
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		localparam int BASE = p * `EGTR_PORT_LANE_BITS;
		egtr_port_type_t ptype;
		logic ins_bit;
		logic cvid_bit;
		logic cpri_bit;
		logic ctag_bit;
		logic is_hybrid;

		assign ptype = egtr_port_type_t'(
			tag_rules_reg[BASE+`EGTR_FLD_TYPE_HI:BASE+`EGTR_FLD_TYPE_LO]);
		assign ins_bit = tag_rules_reg[BASE+`EGTR_FLD_INSERT_TAG];
		assign cvid_bit = tag_rules_reg[BASE+`EGTR_FLD_CHANGE_VID];
		assign cpri_bit = tag_rules_reg[BASE+`EGTR_FLD_CHANGE_PRI];
		assign ctag_bit = tag_rules_reg[BASE+`EGTR_FLD_CHANGE_TAG];
		assign is_hybrid = ptype == EGTR_TYPE_HYBRID;

		always_ff @(posedge clock_in) begin
			if (srst_in) begin
				port_type_out[2*p +: 2] <= 2'h0;
				strip_special_out[p] <= 1'b0;
				strip_all_out[p] <= 1'b0;
				hybrid_out[p] <= 1'b0;
				add_source_tag_out[p] <= 1'b0;
			end else begin
				port_type_out[2*p +: 2] <= ptype;
				// dumb still removes the special tag that host frames carry
				strip_special_out[p] <= ptype == EGTR_TYPE_DUMB;
				strip_all_out[p] <= ptype == EGTR_TYPE_ACCESS;
				hybrid_out[p] <= is_hybrid;
				add_source_tag_out[p] <= ptype == EGTR_TYPE_CPU;
			end
		end

		// enable bits only matter in hybrid; the un-tag bit is applied downstream
		always_ff @(posedge clock_in) begin
			if (srst_in) begin
				insert_untagged_out[p] <= 1'b0;
				change_vid_out[p] <= 1'b0;
				change_pri_out[p] <= 1'b0;
				prio_vid_fix_out[p] <= 1'b0;
			end else begin
				insert_untagged_out[p] <= is_hybrid && ins_bit;
				change_vid_out[p] <= is_hybrid && cvid_bit && ctag_bit;
				change_pri_out[p] <= is_hybrid && cpri_bit && ctag_bit;
				// priority-tagged frames ignore change-tag and change-vid alike
				prio_vid_fix_out[p] <= is_hybrid;
			end
		end
	end

	// ---- pacing slots: queue q reads register q/2, odd queues from the upper field
	for (genvar q = 0; q < NUM_QUEUES; q++) begin : g_queue
		egtr_rate_t rate;

		if (q % 2 == 1) begin : g_odd
			assign rate = rate_reg[q/2][`EGTR_FLD_RATE_ODD_HI:`EGTR_FLD_RATE_ODD_LO];
		end else begin : g_even
			assign rate = rate_reg[q/2][`EGTR_FLD_RATE_EVEN_HI:`EGTR_FLD_RATE_EVEN_LO];
		end

		egtr_pacer u_pacer (
			.clock_in(clock_in),
			.srst_in(srst_in),
			.rate_in(rate),
			.enable_in(pace_enable_in),
			.byte_sent_in(byte_sent_in[q]),
			.credit_out(byte_credit_out[q])
		);
	end

endmodule

`default_nettype wire

// ---- egtr_config_sva.sv ----
// checker for the egress tag and rate configuration block
// assumes it is bound to egtr_config, one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module egtr_config_sva (
	input wire logic clock_in,
	input wire logic srst_in,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic pace_enable_in,
	input wire logic [5:0] byte_sent_in,
	input wire logic [5:0] byte_credit_out,
	input wire logic [5:0] port_type_out,
	input wire logic [2:0] strip_all_out,
	input wire logic [2:0] hybrid_out,
	input wire logic [2:0] add_source_tag_out,
	input wire logic [2:0] insert_untagged_out,
	input wire logic [2:0] change_vid_out,
	input wire logic [2:0] prio_vid_fix_out
);
	logic [1:0] settle_reg;
	logic [2:0] is_access, is_hybrid, is_cpu;
	// decoded outputs lag reset release, so the decode checks wait three edges
	always_ff @(posedge clock_in) begin
		if (srst_in)
			settle_reg <= 2'h0;
		else if (settle_reg != 2'h3)
			settle_reg <= settle_reg + 2'h1;
	end
	// per-port type flags worked out from the type field
	assign is_access = {port_type_out[5:4] == 2'h1, port_type_out[3:2] == 2'h1, port_type_out[1:0] == 2'h1};
	assign is_hybrid = {port_type_out[5:4] == 2'h2, port_type_out[3:2] == 2'h2, port_type_out[1:0] == 2'h2};
	assign is_cpu = {port_type_out[5:4] == 2'h3, port_type_out[3:2] == 2'h3, port_type_out[1:0] == 2'h3};
	default clocking @(posedge clock_in); endclocking
	default disable iff (srst_in);
	property p_type_decode;
		settle_reg == 2'h3 && $stable(port_type_out) |-> strip_all_out == is_access
			&& hybrid_out == is_hybrid && add_source_tag_out == is_cpu;
	endproperty
	a_type_decode: assert property (p_type_decode)
		else $error("type decode wrong");
	property p_hybrid_only;
		((insert_untagged_out | change_vid_out) & ~hybrid_out) == 3'h0;
	endproperty
	a_hybrid_only: assert property (p_hybrid_only)
		else $error("tag change outside hybrid");
	property p_prio_fix;
		settle_reg == 2'h3 && $stable(port_type_out) |-> prio_vid_fix_out == is_hybrid;
	endproperty
	a_prio_fix: assert property (p_prio_fix)
		else $error("priority tag fix wrong");
	property p_write_answer;
		// both halves held after the taking edge, commit one edge later, bvalid seen the next
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
			|-> ##2 s_axi_bvalid_out;
	endproperty
	a_write_answer: assert property (p_write_answer)
		else $error("write response late");
	property p_aw_refused;
		s_axi_awvalid_in && s_axi_awready_out |=> !s_axi_awready_out;
	endproperty
	a_aw_refused: assert property (p_aw_refused)
		else $error("second write address taken");
	property p_b_stands;
		s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out;
	endproperty
	a_b_stands: assert property (p_b_stands)
		else $error("write response dropped");
	property p_r_stands;
		s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
	endproperty
	a_r_stands: assert property (p_r_stands)
		else $error("read data dropped");
	property p_read_answer;
		s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out;
	endproperty
	a_read_answer: assert property (p_read_answer)
		else $error("read data late");
	// even rate zero keeps the next byte off for two clocks, so 20 ns is never undercut
	property p_credit_held;
		pace_enable_in && byte_sent_in[0] && byte_credit_out[0] ##1 pace_enable_in [*2]
			|-> !byte_credit_out[0];
	endproperty
	a_credit_held: assert property (p_credit_held)
		else $error("byte spacing too short");
	property p_credit_free;
		!pace_enable_in |=> byte_credit_out == 6'h3f;
	endproperty
	a_credit_free: assert property (p_credit_free)
		else $error("pacing acts while disabled");
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the egress tag and rate configuration block
// assumes egtr_pkg and egtr_config are compiled first; the bench drives every port
`timescale 1ns/1ps
`default_nettype none
module tb_top import egtr_pkg::*;;
	logic clock_in = 1'b0;
	logic srst_in = 1'b1;
	logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
	logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0, pace_enable_in = 1'b0;
	logic [15:0] s_axi_awaddr_in = 16'h0, s_axi_araddr_in = 16'h0;
	logic [31:0] s_axi_wdata_in = 32'h0;
	logic [3:0] s_axi_wstrb_in = 4'h0;
	logic [5:0] byte_sent_in = 6'h0;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
	logic s_axi_rvalid_out;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out, resp;
	logic [31:0] s_axi_rdata_out, rd;
	logic [5:0] byte_credit_out, port_type_out, ty;
	logic [2:0] strip_special_out, strip_all_out, hybrid_out, add_source_tag_out, hyb, ctag;
	logic [2:0] insert_untagged_out, change_vid_out, change_pri_out, prio_vid_fix_out;
	logic [11:0] en;
	logic [23:0] lane;
	int n_mismatch = 0, samples_checked = 0, lo0, lo1;
	typedef struct {logic [15:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] e;} egtr_row_t;
	// address, write data, strobes, expected read back
	egtr_row_t rows [6] = '{'{16'h7030, 32'hffffffff, 4'hf, 32'h003f3f3f},
		'{16'h7034, 32'hffffffff, 4'hf, 32'h03ffffff}, '{16'h7038, 32'h12345678, 4'hf, 32'h02345678},
		'{16'h703c, 32'haaaa5555, 4'hf, 32'h02aa5555}, '{16'h7030, 32'h00001500, 4'h2, 32'h003f153f},
		'{16'h7034, 32'h00000000, 4'h0, 32'h03ffffff}};
	egtr_config i_egtr_config (.clock_in, .srst_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
		.s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
		.s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
		.s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
		.pace_enable_in, .byte_sent_in, .byte_credit_out, .port_type_out, .strip_special_out,
		.strip_all_out, .hybrid_out, .add_source_tag_out, .insert_untagged_out, .change_vid_out,
		.change_pri_out, .prio_vid_fix_out);
	initial begin
		forever #4 clock_in = ~clock_in;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// address and data go out together; each is released on its own ready
	task automatic axi_write(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clock_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_wstrb_in <= s;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		do begin
			@(posedge clock_in);
			if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
			if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
		end while (s_axi_bvalid_out !== 1'b1);
		resp = s_axi_bresp_out;
		s_axi_bready_in <= 1'b0;
	endtask
	task automatic axi_read(input logic [15:0] a);
		@(posedge clock_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= 1'b1;
		do begin
			@(posedge clock_in);
			if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
		end while (s_axi_rvalid_out !== 1'b1);
		rd = s_axi_rdata_out;
		resp = s_axi_rresp_out;
		s_axi_rready_in <= 1'b0;
	endtask
	task automatic report_and_stop;
		$display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	function automatic logic [2:0] pick(input logic [5:0] t, input logic [1:0] code);
		pick = {t[5:4] == code, t[3:2] == code, t[1:0] == code};
	endfunction
	// hang guard, far beyond the fewer than two hundred cycles the tests need
	initial begin
		#200000;
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		repeat (2) @(posedge clock_in);
		srst_in <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			axi_read(16'h7030 + 16'(4 * i));
			check("reset value", rd, 32'h0);
		end
		check("reset credit", 32'(byte_credit_out), 32'h3f);
		check("reset pass type", 32'(strip_special_out), 32'h7);
		$display("test reset done");
		foreach (rows[i]) begin
			axi_write(rows[i].a, rows[i].d, rows[i].s);
			check("write resp", 32'(resp), 32'(EGTR_RESP_OKAY));
			axi_read(rows[i].a);
			check("read back", rd, rows[i].e);
			check("read resp", 32'(resp), 32'(EGTR_RESP_OKAY));
		end
		$display("test map done");
		// each pass turns every port to a different type and enable mix
		for (int t = 0; t < 4; t++) begin
			for (int p = 0; p < 3; p++) begin
				ty[2*p +: 2] = 2'(t + p);
				en[4*p +: 4] = 4'(t * 5 + p * 6 + 1);
				lane[8*p +: 8] = {2'h0, en[4*p +: 4], ty[2*p +: 2]};
			end
			axi_write(16'h7030, 32'(lane), 4'hf);
			repeat (3) @(posedge clock_in);
			hyb = pick(ty, 2'h2);
			ctag = {en[8], en[4], en[0]};
			check("port type", 32'(port_type_out), 32'(ty));
			check("strip special", 32'(strip_special_out), 32'(pick(ty, 2'h0)));
			check("strip all", 32'(strip_all_out), 32'(pick(ty, 2'h1)));
			check("hybrid", 32'(hybrid_out), 32'(hyb));
			check("source tag", 32'(add_source_tag_out), 32'(pick(ty, 2'h3)));
			check("insert", 32'(insert_untagged_out), 32'(hyb & {en[11], en[7], en[3]}));
			check("change vid", 32'(change_vid_out), 32'(hyb & ctag & {en[10], en[6], en[2]}));
			check("change pri", 32'(change_pri_out), 32'(hyb & ctag & {en[9], en[5], en[1]}));
			check("prio fix", 32'(prio_vid_fix_out), 32'(hyb));
		end
		$display("test decode done");
		axi_write(16'h7040, 32'hffffffff, 4'hf);
		check("unmapped write", 32'(resp), 32'(EGTR_RESP_SLVERR));
		axi_read(16'h7040);
		check("unmapped data", rd, 32'h0);
		check("unmapped read", 32'(resp), 32'(EGTR_RESP_SLVERR));
		$display("test unmapped done");
		// queue 0 at rate 0, queue 1 at rate 1
		axi_write(16'h7034, 32'h00002000, 4'hf);
		pace_enable_in <= 1'b1;
		repeat (3) @(posedge clock_in);
		byte_sent_in <= 6'h03;
		@(posedge clock_in);
		byte_sent_in <= 6'h00;
		lo0 = 0;
		lo1 = 0;
		repeat (12) begin
			@(posedge clock_in);
			if (byte_credit_out[0] === 1'b0) lo0++;
			if (byte_credit_out[1] === 1'b0) lo1++;
		end
		// credit stays low for the byte spacing in whole clocks, less the clock of the byte itself
		check("rate 0 gap", 32'(lo0), 32'((1 * 20 + 7) / 8 - 1));
		check("rate 1 gap", 32'(lo1), 32'((2 * 20 + 7) / 8 - 1));
		pace_enable_in <= 1'b0;
		@(posedge clock_in);
		byte_sent_in <= 6'h3f;
		@(posedge clock_in);
		byte_sent_in <= 6'h00;
		repeat (2) @(posedge clock_in);
		check("pacing off", 32'(byte_credit_out), 32'h3f);
		$display("test pacing done");
		// reset in mid-run must clear stored values again
		srst_in <= 1'b1;
		repeat (2) @(posedge clock_in);
		srst_in <= 1'b0;
		axi_read(16'h7038);
		check("second reset", rd, 32'h0);
		check("second reset type", 32'(port_type_out), 32'h0);
		$display("test second reset done");
		report_and_stop();
	end
endmodule
bind egtr_config egtr_config_sva i_egtr_config_sva (.clock_in, .srst_in, .s_axi_awvalid_in,
	.s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in,
	.s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rvalid_out, .s_axi_rready_in,
	.pace_enable_in, .byte_sent_in, .byte_credit_out, .port_type_out, .strip_all_out, .hybrid_out,
	.add_source_tag_out, .insert_untagged_out, .change_vid_out, .prio_vid_fix_out);
`default_nettype wire
